// File: design/eic_consts.svh
// Constants for the external interrupt input conditioner
//
// Overview of operation
// - Forbidden fetch: reset or trap interrupt, chosen by watchdog setting.
// - Trap request is raised at once, even during non-maskable service.
// - Six external inputs, each through a digital noise rejection stage.
// - Zero pin: port bit when select 0, interrupt when 1; resets as port.
// - Input zero uses falling edges; its latch stays clear in port function.
// - Fast clock: inputs zero and five reject under 2, accept 7 periods.
// - Input one filter select: 1 gives 15/49 periods, 0 gives 63/193.
// - Fast clock: inputs two, three, four reject under 7, accept 25 periods.
// - Slow and sleep modes: reject under 1, accept 3.5 low-clock periods.
// - Clean edge sets latch by establishment time plus 6 low-clock periods.
// - Inputs one to three: select 0 means rising edge, 1 falling edge.
// - Input four trigger: 00 rise, 01 fall, 10 both, 11 high level.
// - New input-one filter length applies within 64 fast-clock periods.
// - Input four high at reset release needs a rising edge before a high-level request.
// - Accepting an external interrupt clears that source's latch.
`ifndef EIC_CONSTS_SVH
`define EIC_CONSTS_SVH

// Register offsets
`define EIC_OFF_CONTROL 8'h37
`define EIC_OFF_STATUS 8'h40
`define EIC_OFF_MASK 8'h41
`define EIC_OFF_LATCH 8'h42

// Control register fields
`define EIC_BIT_ONE_NC 7
`define EIC_BIT_ZERO_EN 6
`define EIC_BIT_FOUR_HI 5
`define EIC_BIT_FOUR_LO 4
`define EIC_BIT_THREE_ES 3
`define EIC_BIT_TWO_ES 2
`define EIC_BIT_ONE_ES 1
`define EIC_CONTROL_RESET 8'h00

// Status bit of the address trap event
`define EIC_STAT_TRAP 6

// Filter limits in fast-clock periods (the system clock is the fast clock)
`define EIC_REJ_ZERO_FIVE 2
`define EIC_ACC_ZERO_FIVE 7
`define EIC_REJ_ONE_SHORT 15
`define EIC_ACC_ONE_SHORT 49
`define EIC_REJ_ONE_LONG 63
`define EIC_ACC_ONE_LONG 193
`define EIC_REJ_OTHERS 7
`define EIC_ACC_OTHERS 25
// Acceptance counts sit midway between the reject and accept limits
`define EIC_CNT_ZERO_FIVE ((`EIC_REJ_ZERO_FIVE + `EIC_ACC_ZERO_FIVE) / 2)
`define EIC_CNT_ONE_SHORT ((`EIC_REJ_ONE_SHORT + `EIC_ACC_ONE_SHORT) / 2)
`define EIC_CNT_ONE_LONG ((`EIC_REJ_ONE_LONG + `EIC_ACC_ONE_LONG) / 2)
`define EIC_CNT_OTHERS ((`EIC_REJ_OTHERS + `EIC_ACC_OTHERS) / 2)
// Slow mode: reject under 1, accept 3.5 low-clock periods; 2 samples
`define EIC_CNT_SLOW 2
// Longest allowed switch time of the input-one filter length
`define EIC_NC_SWITCH_MAX 64

`endif

// File: design/eic_pkg.sv
// Types for the external interrupt input conditioner
package eic_pkg;
    typedef logic [7:0] eic_byte_t;
    typedef enum logic [1:0] {
        EIC_TRIG_RISE = 2'h0,
        EIC_TRIG_FALL = 2'h1,
        EIC_TRIG_BOTH = 2'h2,
        EIC_TRIG_HIGH = 2'h3
    } eic_trig_t;
endpackage : eic_pkg

// File: design/eic_noise_filter.sv
// One digital noise rejection stage with edge pulses
`timescale 1ns/1ps
module eic_noise_filter #(
    parameter int CNT_W = 8
) (
    input wire logic clk, // Fast system clock
    input wire logic reset, // Synchronous reset, active high
    input wire logic sample_tick, // Take a sample this cycle
    input wire logic din, // Synchronised pin level
    input wire logic [CNT_W-1:0] thresh, // Samples needed to accept
    output logic dout, // Filtered level
    output logic rise, // One-cycle rising pulse
    output logic fall // One-cycle falling pulse
);
    logic level_reg;
    logic primed_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic rise_reg;
    logic fall_reg;
    wire logic differ;
    wire logic take;

    // Elaboration check on the counter width
    if (CNT_W < 2 || CNT_W > 16) begin : g_bad_width
        $error("eic_noise_filter: CNT_W out of range");
    end

    // Count differing samples; any agreeing sample restarts the count
    assign differ = (din != level_reg) || !primed_reg;
    assign cnt_next = cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
    assign take = differ && sample_tick && (cnt_next >= thresh);

    // First accepted level after reset is loaded without an edge,
    // so a pin already high at release does not look like a rising edge
    always_ff @(posedge clk) begin
        if (reset) begin
            level_reg <= 1'b0;
            primed_reg <= 1'b0;
            cnt_reg <= '0;
            rise_reg <= 1'b0;
            fall_reg <= 1'b0;
        end else begin
            rise_reg <= take && primed_reg && din;
            fall_reg <= take && primed_reg && !din;
            if (!differ || take) begin
                cnt_reg <= '0;
            end else if (sample_tick) begin
                cnt_reg <= cnt_next;
            end
            if (take) begin
                level_reg <= din;
                primed_reg <= 1'b1;
            end
        end
    end

    assign dout = level_reg;
    assign rise = rise_reg;
    assign fall = fall_reg;
endmodule : eic_noise_filter

// File: design/eic_top.sv
// External interrupt input conditioner with address trap handling
`include "eic_consts.svh"
`timescale 1ns/1ps
module eic_top #(
    parameter int CNT_W = 8, // Filter counter width
    parameter int N_IN = 6 // Number of external inputs
) (
    input wire logic clk, // 20 MHz fast clock
    input wire logic reset, // Synchronous reset, active high
    input wire logic [7:0] addr, // Register address
    input wire logic [7:0] wdata, // Register write data
    input wire logic we, // Write strobe
    input wire logic re, // Read strobe
    output logic [7:0] rdata, // Read data, cycle after re
    input wire logic [N_IN-1:0] ext_irq_in, // Interrupt pins, bit i = input i
    input wire logic low_freq_clock, // Low clock, sampled as a pin
    input wire logic slow_mode, // Low-speed or sleep mode active
    input wire logic [N_IN-1:0] irq_accept, // CPU accepted source i
    input wire logic fetch_trapped, // Fetch from a forbidden area
    input wire logic trap_to_irq, // Watchdog setting: 1 trap irq
    input wire logic trap_accept, // CPU accepted the address trap
    output logic [N_IN-1:0] irq_latch, // Interrupt latches
    output logic address_trap_interrupt, // Address trap request
    output logic trap_reset_out, // Reset request from a trap
    output logic shared_port_bit_zero, // Zero pin as port input
    output logic irq // Level interrupt output
);
    ////////////////////////////////////////////////////////////////////////
    // Declarations
    ////////////////////////////////////////////////////////////////////////
    eic_pkg::eic_byte_t ext_irq_control_reg;
    logic [6:0] status_reg;
    logic [6:0] status_next;
    logic [6:0] mask_reg;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic [N_IN-1:0] latch_reg;
    logic [N_IN-1:0] latch_next;
    logic [N_IN-1:0] pin_meta_reg;
    logic [N_IN-1:0] pin_sync_reg;
    logic fs_meta_reg;
    logic fs_sync_reg;
    logic fs_prev_reg;
    logic four_armed_reg;
    logic trap_irq_reg;
    logic trap_rst_reg;
    logic port_zero_reg;
    logic irq_reg;
    logic [N_IN-1:0] filt_level;
    logic [N_IN-1:0] filt_rise;
    logic [N_IN-1:0] filt_fall;
    wire logic [N_IN-1:0] event_hit;
    logic hit_four;
    logic [CNT_W-1:0] thresh [N_IN];
    wire logic fs_tick;
    wire logic sample_tick;
    wire logic wr_control;
    wire logic wr_status;
    wire logic wr_mask;
    wire logic zero_en;
    wire logic one_nc;
    eic_pkg::eic_trig_t four_trig;
    wire logic [CNT_W-1:0] th_zero_five;
    wire logic [CNT_W-1:0] th_one;
    wire logic [CNT_W-1:0] th_others;
    wire logic [CNT_W-1:0] th_slow;
    wire logic [6:0] status_set;

    // Elaboration checks: six fixed inputs, counter wide enough
    if (N_IN != 6) begin : g_bad_inputs
        $error("eic_top: N_IN must be 6");
    end
    if ((1 << CNT_W) <= `EIC_CNT_ONE_LONG || CNT_W > 16) begin : g_bad_width
        $error("eic_top: CNT_W too small for the filter counts");
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    ////////////////////////////////////////////////////////////////////////
    // Two flops on every pin and on the low clock before any logic
    always_ff @(posedge clk) begin
        if (reset) begin
            pin_meta_reg <= '0;
            pin_sync_reg <= '0;
            fs_meta_reg <= 1'b0;
            fs_sync_reg <= 1'b0;
            fs_prev_reg <= 1'b0;
        end else begin
            pin_meta_reg <= ext_irq_in;
            pin_sync_reg <= pin_meta_reg;
            fs_meta_reg <= low_freq_clock;
            fs_sync_reg <= fs_meta_reg;
            fs_prev_reg <= fs_sync_reg;
        end
    end

    // Low clock rising edge paces the filters in slow modes
    assign fs_tick = fs_sync_reg && !fs_prev_reg;
    assign sample_tick = slow_mode ? fs_tick : 1'b1;

    ////////////////////////////////////////////////////////////////////////
    // Control fields and filter thresholds
    ////////////////////////////////////////////////////////////////////////
    assign zero_en = ext_irq_control_reg[`EIC_BIT_ZERO_EN];
    assign one_nc = ext_irq_control_reg[`EIC_BIT_ONE_NC];
    assign four_trig = eic_pkg::eic_trig_t'(
        ext_irq_control_reg[`EIC_BIT_FOUR_HI:`EIC_BIT_FOUR_LO]);
    assign th_zero_five = CNT_W'(`EIC_CNT_ZERO_FIVE);
    // Length select acts on the next sample, well inside 64 cycles
    assign th_one = one_nc ? CNT_W'(`EIC_CNT_ONE_SHORT)
                           : CNT_W'(`EIC_CNT_ONE_LONG);
    assign th_others = CNT_W'(`EIC_CNT_OTHERS);
    assign th_slow = CNT_W'(`EIC_CNT_SLOW);

    // Per-input threshold; slow modes use one common sample count
    always_comb begin
        thresh[0] = slow_mode ? th_slow : th_zero_five;
        thresh[1] = slow_mode ? th_slow : th_one;
        thresh[2] = slow_mode ? th_slow : th_others;
        thresh[3] = slow_mode ? th_slow : th_others;
        thresh[4] = slow_mode ? th_slow : th_others;
        thresh[5] = slow_mode ? th_slow : th_zero_five;
    end

    ////////////////////////////////////////////////////////////////////////
    // Noise filters
    ////////////////////////////////////////////////////////////////////////
    // Filter delay is up to 128 fast cycles or 2 low-clock samples, far below 6 low-clock periods
    for (genvar i = 0; i < N_IN; i++) begin : g_filt
        eic_noise_filter #(
            .CNT_W(CNT_W)
        ) u_filt (
            .clk(clk),
            .reset(reset),
            .sample_tick(sample_tick),
            .din(pin_sync_reg[i]),
            .thresh(thresh[i]),
            .dout(filt_level[i]),
            .rise(filt_rise[i]),
            .fall(filt_fall[i])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // Trigger selection
    ////////////////////////////////////////////////////////////////////////
    // Input zero counts only in interrupt function
    assign event_hit[0] = zero_en && filt_fall[0];
    assign event_hit[1] = ext_irq_control_reg[`EIC_BIT_ONE_ES]
                          ? filt_fall[1] : filt_rise[1];
    assign event_hit[2] = ext_irq_control_reg[`EIC_BIT_TWO_ES]
                          ? filt_fall[2] : filt_rise[2];
    assign event_hit[3] = ext_irq_control_reg[`EIC_BIT_THREE_ES]
                          ? filt_fall[3] : filt_rise[3];
    assign event_hit[5] = filt_fall[5];
    assign event_hit[4] = hit_four;

    // Input four trigger decode
    always_comb begin
        hit_four = 1'b0;
        unique case (four_trig)
            eic_pkg::EIC_TRIG_RISE: hit_four = filt_rise[4];
            eic_pkg::EIC_TRIG_FALL: hit_four = filt_fall[4];
            eic_pkg::EIC_TRIG_BOTH: hit_four = filt_rise[4]
                                               | filt_fall[4];
            eic_pkg::EIC_TRIG_HIGH: hit_four = four_armed_reg
                                               && filt_level[4];
        endcase
    end

    // Level mode arms only after a filtered rising edge since reset
    always_ff @(posedge clk) begin
        if (reset) begin
            four_armed_reg <= 1'b0;
        end else if (filt_rise[4]) begin
            four_armed_reg <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt latches
    ////////////////////////////////////////////////////////////////////////
    // Acceptance clears a latch, but a new event in the same cycle wins
    assign latch_next = (latch_reg & ~irq_accept) | event_hit;

    always_ff @(posedge clk) begin
        if (reset) begin
            latch_reg <= '0;
        end else begin
            latch_reg <= latch_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Address trap
    ////////////////////////////////////////////////////////////////////////
    // Trap request ignores any non-maskable service in progress
    always_ff @(posedge clk) begin
        if (reset) begin
            trap_irq_reg <= 1'b0;
            trap_rst_reg <= 1'b0;
        end else begin
            trap_rst_reg <= fetch_trapped && !trap_to_irq;
            if (fetch_trapped && trap_to_irq) begin
                trap_irq_reg <= 1'b1;
            end else if (trap_accept) begin
                trap_irq_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register bus
    ////////////////////////////////////////////////////////////////////////
    assign wr_control = we && (addr == `EIC_OFF_CONTROL);
    assign wr_status = we && (addr == `EIC_OFF_STATUS);
    assign wr_mask = we && (addr == `EIC_OFF_MASK);
    assign status_set = {fetch_trapped && trap_to_irq, event_hit};
    // Write-one-to-clear; a set in the same cycle wins
    assign status_next = (status_reg & ~(wr_status ? wdata[6:0] : 7'h00))
                         | status_set;

    // Read mux; unmapped addresses read zero
    always_comb begin
        rdata_next = 8'h00;
        if (re) begin
            unique case (addr)
                `EIC_OFF_CONTROL: rdata_next = {ext_irq_control_reg[7:1],
                                                1'b0};
                `EIC_OFF_STATUS: rdata_next = {1'b0, status_reg};
                `EIC_OFF_MASK: rdata_next = {1'b0, mask_reg};
                `EIC_OFF_LATCH: rdata_next = {2'h0, latch_reg};
                default: rdata_next = 8'h00;
            endcase
        end
    end

    // Control register resets to port function on the zero pin
    always_ff @(posedge clk) begin
        if (reset) begin
            ext_irq_control_reg <= `EIC_CONTROL_RESET;
        end else if (wr_control) begin
            ext_irq_control_reg <= {wdata[7:1], 1'b0};
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            status_reg <= 7'h00;
            mask_reg <= 7'h00;
            rdata_reg <= 8'h00;
            irq_reg <= 1'b0;
        end else begin
            status_reg <= status_next;
            if (wr_mask) begin
                mask_reg <= wdata[6:0];
            end
            rdata_reg <= rdata_next;
            irq_reg <= |(status_next & (wr_mask ? wdata[6:0] : mask_reg));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Port function of the zero pin
    ////////////////////////////////////////////////////////////////////////
    // Port input shows the synchronised pin only in port function
    always_ff @(posedge clk) begin
        if (reset) begin
            port_zero_reg <= 1'b0;
        end else begin
            port_zero_reg <= !zero_en && pin_sync_reg[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    ////////////////////////////////////////////////////////////////////////
    assign rdata = rdata_reg;
    assign irq_latch = latch_reg;
    assign address_trap_interrupt = trap_irq_reg;
    assign trap_reset_out = trap_rst_reg;
    assign shared_port_bit_zero = port_zero_reg;
    assign irq = irq_reg;
endmodule : eic_top

// File: tb/eic_pin_source.sv
// Pin-side model of the six external interrupt sources
`timescale 1ns/1ps
module eic_pin_source (
    input wire logic clk, // Fast clock, times the pulses
    output logic [5:0] pins, // Pin levels, idle high
    output logic lfc // Low clock, runs free
);
    // Low clock keeps running, phase unrelated to clk
    initial lfc = 1'b0;
    always #410 lfc = ~lfc;
    initial pins = 6'h3f;
    // Level change made right after a clk edge
    task drive(input int i, input logic v);
        pins[i] <= v;
    endtask : drive
    // Pulse of n clk periods, then back to the other level
    task pulse(input int i, input logic v, input int n);
        pins[i] <= v;
        repeat (n) @(posedge clk);
        pins[i] <= ~v;
    endtask : pulse
endmodule : eic_pin_source

// File: tb/eic_checker.sv
// Port-level assertions for the interrupt input conditioner
`timescale 1ns/1ps
`include "eic_consts.svh"
module eic_checker #(
    parameter int CNT_W = 8,
    parameter int N_IN = 6
) (
    input wire logic clk, // Clock
    input wire logic reset, // Reset
    input wire logic [7:0] addr, // Address
    input wire logic [7:0] wdata, // Write data
    input wire logic we, // Write strobe
    input wire logic [N_IN-1:0] irq_accept, // Latch accepts
    input wire logic fetch_trapped, // Forbidden fetch
    input wire logic trap_to_irq, // Trap mode
    input wire logic trap_accept, // Trap accepted
    input wire logic [N_IN-1:0] irq_latch, // Latches
    input wire logic address_trap_interrupt, // Trap request
    input wire logic trap_reset_out, // Trap reset
    input wire logic irq // Level interrupt
);
    logic zen_reg; // Zero pin in interrupt function
    logic mz_reg; // Mask is all zero
    ////////////////////////////////////////////////////////////////////////
    // Mirror of control and mask, rebuilt from bus writes only
    always_ff @(posedge clk) begin
        if (reset) begin
            zen_reg <= 1'b0;
            mz_reg <= 1'b1;
        end else if (we && addr == `EIC_OFF_CONTROL) begin
            zen_reg <= wdata[`EIC_BIT_ZERO_EN];
        end else if (we && addr == `EIC_OFF_MASK) begin
            mz_reg <= (wdata == 8'h00);
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    a_trap_raise: assert property (fetch_trapped && trap_to_irq
        |=> address_trap_interrupt) else $error("trap request missing");
    a_trap_cause: assert property ($rose(address_trap_interrupt)
        |-> $past(fetch_trapped) && $past(trap_to_irq))
        else $error("trap request without trapped fetch");
    a_reset_pulse: assert property (fetch_trapped && !trap_to_irq
        |=> trap_reset_out) else $error("trap reset missing");
    a_reset_cause: assert property (trap_reset_out
        |-> $past(fetch_trapped) && !$past(trap_to_irq))
        else $error("trap reset without cause");
    a_trap_hold: assert property (address_trap_interrupt
        && !trap_accept |=> address_trap_interrupt)
        else $error("trap request dropped early");
    a_trap_clear: assert property (trap_accept && !fetch_trapped
        |=> !address_trap_interrupt) else $error("trap not cleared");
    a_latch_clear: assert property (
        ($past(irq_latch) & ~irq_latch & ~$past(irq_accept)) == '0)
        else $error("latch cleared without accept");
    a_zero_block: assert property (!zen_reg && !irq_latch[0]
        |=> !irq_latch[0]) else $error("zero latch set in port use");
    a_irq_masked: assert property (mz_reg |-> !irq)
        else $error("irq high with mask zero");
endmodule : eic_checker
bind eic_top eic_checker #(.CNT_W(CNT_W), .N_IN(N_IN)) u_chk (
    .clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .we(we),
    .irq_accept(irq_accept), .fetch_trapped(fetch_trapped),
    .trap_to_irq(trap_to_irq), .trap_accept(trap_accept),
    .irq_latch(irq_latch), .address_trap_interrupt(address_trap_interrupt),
    .trap_reset_out(trap_reset_out), .irq(irq)
);

// File: tb/eic_top_tb_top.sv
// Self-checking bench for the interrupt input conditioner
`timescale 1ns/1ps
`include "eic_consts.svh"
module eic_top_tb_top;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic we = 1'b0;
    logic re = 1'b0;
    logic slow_mode = 1'b0;
    logic [5:0] irq_accept = 6'h00;
    logic fetch_trapped = 1'b0;
    logic trap_to_irq = 1'b0;
    logic trap_accept = 1'b0;
    logic [7:0] rdata;
    logic [5:0] pins;
    logic [5:0] lat;
    logic lfc;
    logic trap_irq;
    logic trap_rst;
    logic port0;
    logic irq;
    int mismatches = 0;
    int comparisons = 0;
    ////////////////////////////////////////////////////////////////////////
    // 20 MHz fast clock
    always #25 clk = ~clk;
    eic_pin_source src (.clk(clk), .pins(pins), .lfc(lfc));
    eic_top dut (
        .clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .we(we),
        .re(re), .rdata(rdata), .ext_irq_in(pins), .low_freq_clock(lfc),
        .slow_mode(slow_mode), .irq_accept(irq_accept),
        .fetch_trapped(fetch_trapped), .trap_to_irq(trap_to_irq),
        .trap_accept(trap_accept), .irq_latch(lat),
        .address_trap_interrupt(trap_irq), .trap_reset_out(trap_rst),
        .shared_port_bit_zero(port0), .irq(irq)
    );
    ////////////////////////////////////////////////////////////////////////
    // Shared helpers; values are read at the edge, before it updates them
    task chk(input logic [7:0] g, input logic [7:0] e);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask : chk
    task chb(input logic b, input int e);
        chk(8'(b), 8'(e));
    endtask : chb
    task wt(input int n);
        repeat (n) @(posedge clk);
    endtask : wt
    // One idle edge after each strobe keeps drivers one write per step
    task wr(input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        we <= 1'b1;
        wt(1);
        we <= 1'b0;
        wt(1);
    endtask : wr
    task rd(input logic [7:0] a, input logic [7:0] e);
        addr <= a;
        re <= 1'b1;
        wt(1);
        re <= 1'b0;
        wt(1);
        chk(rdata, e);
    endtask : rd
    task acc(input int i);
        irq_accept <= 6'(1 << i);
        wt(1);
        irq_accept <= 6'h00;
        wt(1);
    endtask : acc
    task trap(input logic to_irq);
        trap_to_irq <= to_irq;
        fetch_trapped <= 1'b1;
        wt(1);
        fetch_trapped <= 1'b0;
        wt(1);
    endtask : trap
    ////////////////////////////////////////////////////////////////////////
    // Reset values, read-back, read-only and unmapped places
    task t_regs;
        rd(`EIC_OFF_CONTROL, 8'h00);
        rd(`EIC_OFF_MASK, 8'h00);
        wr(`EIC_OFF_CONTROL, 8'hff);
        rd(`EIC_OFF_CONTROL, 8'hfe);
        wr(`EIC_OFF_CONTROL, 8'h00);
        wr(`EIC_OFF_LATCH, 8'hff);
        rd(`EIC_OFF_LATCH, 8'h00);
        wr(8'h55, 8'hff);
        rd(8'h55, 8'h00);
        $display("test regs done");
    endtask : t_regs
    // Trap as interrupt with mask and clear, then as reset pulse
    task t_trap;
        wr(`EIC_OFF_MASK, 8'h40);
        trap(1'b1);
        chb(trap_irq, 1);
        chb(irq, 1);
        rd(`EIC_OFF_STATUS, 8'h40);
        wr(`EIC_OFF_MASK, 8'h00);
        chb(irq, 0);
        wr(`EIC_OFF_MASK, 8'h40);
        chb(irq, 1);
        wr(`EIC_OFF_STATUS, 8'h40);
        chb(irq, 0);
        trap_accept <= 1'b1;
        wt(1);
        trap_accept <= 1'b0;
        wt(1);
        chb(trap_irq, 0);
        trap(1'b0);
        chb(trap_rst, 1);
        wt(1);
        chb(trap_rst, 0);
        chb(trap_irq, 0);
        wr(`EIC_OFF_MASK, 8'h00);
        wr(`EIC_OFF_STATUS, 8'hff);
        $display("test trap done");
    endtask : t_trap
    // Zero pin as port, then as falling-edge input
    task t_zero;
        // Sources stay masked while the shared pin changes level
        wr(`EIC_OFF_MASK, 8'h00);
        chb(port0, 1);
        src.drive(0, 1'b0);
        wt(30);
        chb(port0, 0);
        chb(lat[0], 0);
        src.drive(0, 1'b1);
        wt(10);
        // Port bit reads zero once the pin is in interrupt function
        wr(`EIC_OFF_CONTROL, 8'h40);
        wt(4);
        chb(port0, 0);
        src.pulse(0, 1'b0, 10);
        wt(10);
        chb(lat[0], 1);
        acc(0);
        $display("test zero done");
    endtask : t_zero
    // Input five: glitch dropped, clean pulse latched in time
    task t_five;
        src.pulse(5, 1'b0, 1);
        wt(30);
        chb(lat[5], 0);
        src.pulse(5, 1'b0, 7);
        wt(96);
        chb(lat[5], 1);
        acc(5);
        chb(lat[5], 0);
        $display("test five done");
    endtask : t_five
    // Input one, both lengths; the long setting comes first
    task t_one;
        for (int k = 0; k < 2; k++) begin
            wr(`EIC_OFF_CONTROL, k ? 8'hc2 : 8'h42);
            wt(64);
            src.pulse(1, 1'b0, k ? 14 : 62);
            wt(40);
            chb(lat[1], 0);
            src.pulse(1, 1'b0, k ? 49 : 193);
            wt(8);
            chb(lat[1], 1);
            acc(1);
        end
        $display("test one done");
    endtask : t_one
    // Edge selectors of inputs one to three, then input two limits
    task t_edges;
        for (int i = 1; i < 4; i++) begin
            for (int s = 0; s < 2; s++) begin
                wr(`EIC_OFF_CONTROL, 8'h80 | 8'(s << i));
                src.drive(i, 1'b0);
                wt(60);
                chb(lat[i], s);
                acc(i);
                src.drive(i, 1'b1);
                wt(60);
                chb(lat[i], 1 - s);
                acc(i);
            end
        end
        // Falling edge on input two for the limit pulses
        wr(`EIC_OFF_CONTROL, 8'h84);
        src.pulse(2, 1'b0, 6);
        wt(40);
        chb(lat[2], 0);
        src.pulse(2, 1'b0, 25);
        wt(8);
        chb(lat[2], 1);
        acc(2);
        $display("test edges done");
    endtask : t_edges
    // Input four: high since reset, then every trigger mode
    task t_four;
        wr(`EIC_OFF_CONTROL, 8'h30);
        wt(60);
        chb(lat[4], 0);
        for (int m = 0; m < 4; m++) begin
            src.drive(4, 1'b0);
            wt(60);
            acc(4);
            wr(`EIC_OFF_CONTROL, {2'b00, 2'(m), 4'h0});
            src.drive(4, 1'b1);
            wt(60);
            chb(lat[4], m != 1);
            acc(4);
            chb(lat[4], m == 3);
            src.drive(4, 1'b0);
            wt(60);
            chb(lat[4], m != 0);
        end
        acc(4);
        $display("test four done");
    endtask : t_four
    // Slow mode filtering on the low clock
    task t_slow;
        slow_mode <= 1'b1;
        wt(40);
        src.pulse(5, 1'b0, 5);
        wt(60);
        chb(lat[5], 0);
        src.pulse(5, 1'b0, 58);
        wt(40);
        chb(lat[5], 1);
        acc(5);
        slow_mode <= 1'b0;
        $display("test slow done");
    endtask : t_slow
    task test_done;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : test_done
    ////////////////////////////////////////////////////////////////////////
    // Tests take near 2700 cycles; the guard allows eleven times that
    initial begin
        repeat (30000) @(posedge clk);
        mismatches++;
        test_done();
    end
    initial begin
        wt(10);
        reset <= 1'b0;
        wt(1);
        t_regs();
        t_trap();
        t_zero();
        t_five();
        t_one();
        t_edges();
        t_four();
        t_slow();
        test_done();
    end
endmodule : eic_top_tb_top
